// ### hw/batt_duty_pkg.sv
package batt_duty_pkg;
	// Register byte addresses
	localparam logic [7:0]  ADDR_TIMING_WORD = 8'h00;
	localparam logic [7:0]  ADDR_LIVE_WORD   = 8'h04;
	localparam logic [7:0]  ADDR_STATUS      = 8'h08;
	localparam logic [7:0]  ADDR_CONTROL     = 8'h0c;
	// Field positions in the 16-bit word (bit 15 is printed bit 0)
	localparam int          POS_DUTY  = 14;
	localparam int          POS_FADE  = 12;
	localparam int          POS_INIT  = 8;
	localparam int          POS_UNITS = 6;
	localparam int          POS_IDLE  = 2;
	localparam int          POS_SENS  = 0;
	localparam logic [15:0] RESET_TIMING_WORD = 16'h0000;
	localparam logic [1:0]  RESET_SENS        = 2'h1;
	// Timing in ns, at a 10 ns clock
	localparam int          CLK_NS      = 10;
	localparam int          DET_ON_NS   = 50000;
	localparam int          DET_OFF0_NS = 50000;
	localparam int          DET_OFF1_NS = 150000;
	localparam int          DET_OFF2_NS = 350000;
	localparam int          FADE0_NS    = 125000;
	localparam int          FADE1_NS    = 1000000;
	localparam int          FADE2_NS    = 10000000;
	localparam int          FADE3_NS    = 100000000;
	// Tick period of the timeout counters: 10 ms
	localparam int          TICK_NS     = 10000000;
	localparam int          TICK_CYC    = TICK_NS / CLK_NS;
	localparam int          US_CYC      = 1000 / CLK_NS;
	// Idle units in ticks of 10 ms
	localparam logic [12:0] UNIT0_TICKS = 13'd1;
	localparam logic [12:0] UNIT1_TICKS = 13'd100;
	localparam logic [12:0] UNIT2_TICKS = 13'd400;
	localparam logic [12:0] UNIT3_TICKS = 13'd6400;
	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b01,
		ST_SLEEP  = 2'b10
	} power_state_t;
endpackage

// ### hw/interval_timer.sv
// Down-counter that flags done once N ticks have passed since start
module interval_timer (
	input  wire logic        i_clk_sys,
	input  wire logic        i_srst,
	input  wire logic        i_start,
	input  wire logic        i_tick,
	input  wire logic [20:0] i_count,
	output logic             o_done
);
	import batt_duty_pkg::*;

	logic [20:0] cnt_r;
	logic [20:0] cnt_nxt;
	logic        run_r;
	logic        run_nxt;
	logic        done_r;
	logic        done_nxt;

	// Count ticks; a zero count never expires
	always_comb begin
		cnt_nxt  = cnt_r;
		run_nxt  = run_r;
		done_nxt = done_r;
		if (i_start) begin
			cnt_nxt  = i_count + 21'h1; // first tick is partial
			run_nxt  = (i_count != 21'h0);
			done_nxt = 1'b0;
		end else if (run_r && i_tick) begin
			if (cnt_r == 21'h1) begin
				run_nxt  = 1'b0;
				done_nxt = 1'b1;
			end
			cnt_nxt = cnt_r - 21'h1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			cnt_r  <= 21'h0;
			run_r  <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			run_r  <= run_nxt;
			done_r <= done_nxt;
		end
	end

	assign o_done = done_r;
endmodule

// ### hw/battery_duty_cycle_control.sv
module battery_duty_cycle_control (
	input  wire logic        i_clk_sys,
	input  wire logic        i_srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        i_field_detect,
	input  wire logic        i_rf_cmd_busy,
	input  wire logic        i_rf_cmd_rx,
	input  wire logic        i_rf_energize,
	input  wire logic        i_battery_ok,
	input  wire logic        i_battery_assisted_mode,
	input  wire logic        i_serial_boot_command,
	output logic             o_detector_en,
	output logic             o_sleep,
	output logic [3:0]       o_sensitivity_sel,
	output logic             o_init_timeout,
	output logic             o_idle_timeout
);
	import batt_duty_pkg::*;

	localparam int ON_CYC   = DET_ON_NS / CLK_NS;

	// Cycle count of a detector off time
	function automatic logic [15:0] off_cycles(input logic [1:0] code);
		case (code)
			2'h1:    off_cycles = 16'(DET_OFF0_NS / CLK_NS);
			2'h2:    off_cycles = 16'(DET_OFF1_NS / CLK_NS);
			default: off_cycles = 16'(DET_OFF2_NS / CLK_NS);
		endcase
	endfunction

	// Fade time in clock cycles
	function automatic logic [23:0] fade_cycles(input logic [1:0] code);
		case (code)
			2'h0:    fade_cycles = 24'(FADE0_NS / CLK_NS);
			2'h1:    fade_cycles = 24'(FADE1_NS / CLK_NS);
			2'h2:    fade_cycles = 24'(FADE2_NS / CLK_NS);
			default: fade_cycles = 24'(FADE3_NS / CLK_NS);
		endcase
	endfunction

	// Pin synchronisers, two flops each
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;
	logic [6:0] pins;
	assign pins = {i_field_detect, i_rf_cmd_busy, i_rf_cmd_rx, i_rf_energize,
		i_battery_ok, i_battery_assisted_mode, i_serial_boot_command};
	always_ff @(posedge i_clk_sys) begin // Unreset: pins high in reset give no edge
		sync1_r <= pins;
		sync2_r <= sync1_r;
	end
	logic field_s, busy_s, cmd_s, energ_s, batt_s, assist_s, sboot_s;
	assign {field_s, busy_s, cmd_s, energ_s, batt_s, assist_s, sboot_s} = sync2_r;

	// Registers and state
	logic [15:0]  word_r, word_nxt;
	logic [1:0]   sens_r, sens_nxt;
	logic [2:0]   prev_r, prev_nxt;
	logic         boot_r, boot_nxt;
	logic [15:0]  duty_cnt_r, duty_cnt_nxt;
	logic         det_on_r, det_on_nxt;
	logic [23:0]  fade_cnt_r, fade_cnt_nxt;
	power_state_t state_r, state_nxt;
	logic [19:0]  tick_cnt_r, tick_cnt_nxt;
	logic         tick_r, tick_nxt;
	logic         restart_r, restart_nxt;
	logic [31:0]  prdata_r, prdata_nxt;
	logic         pready_r, pready_nxt;
	logic         pslverr_r, pslverr_nxt;
	logic [3:0]   sens_dec;
	logic [20:0]  idle_count;
	logic         init_done, idle_done;

	// Field views of the timing word
	logic [1:0] duty_f, fade_f, units_f;
	logic [3:0] init_f, idle_f;
	assign duty_f  = word_r[POS_DUTY +: 2];
	assign fade_f  = word_r[POS_FADE +: 2];
	assign init_f  = word_r[POS_INIT +: 4];
	assign units_f = word_r[POS_UNITS +: 2];
	assign idle_f  = word_r[POS_IDLE +: 4];

	// Sensitivity decode to one-hot select
	always_comb begin
		case (sens_r)
			2'h0:    sens_dec = 4'h1;
			2'h1:    sens_dec = 4'h2;
			2'h2:    sens_dec = 4'h4;
			default: sens_dec = 4'h8;
		endcase
	end

	// Idle timeout in 10 ms ticks by units
	always_comb begin
		case (units_f)
			2'h0:    idle_count = 21'(idle_f) * 21'(UNIT0_TICKS);
			2'h1:    idle_count = 21'(idle_f) * 21'(UNIT1_TICKS);
			2'h2:    idle_count = 21'(idle_f) * 21'(UNIT2_TICKS);
			default: idle_count = 21'(idle_f) * 21'(UNIT3_TICKS);
		endcase
	end

	// APB slave, boot latch and sequencing
	always_comb begin
		word_nxt     = word_r;
		sens_nxt     = sens_r;
		prev_nxt     = {energ_s, batt_s, sboot_s};
		boot_nxt     = 1'b0;
		prdata_nxt   = 32'h0;
		pready_nxt   = 1'b0;
		pslverr_nxt  = 1'b0;
		restart_nxt  = cmd_s;
		// Boot events on rising edges
		if ((energ_s && !prev_r[2] && !assist_s) || (batt_s && !prev_r[1] && assist_s)
			|| (sboot_s && !prev_r[0])) begin
			boot_nxt = 1'b1;
		end
		if (boot_r) begin
			sens_nxt    = word_r[POS_SENS +: 2];
			restart_nxt = 1'b1;
		end
		// One wait state; read data and error set up at the first access edge
		if (psel && penable && !pready_r) begin
			pready_nxt = 1'b1;
			case (paddr)
				ADDR_TIMING_WORD: prdata_nxt = {16'h0, word_r};
				ADDR_LIVE_WORD:   prdata_nxt = {30'h0, sens_r};
				ADDR_STATUS:      prdata_nxt = {27'h0, idle_done, init_done,
					det_on_r, state_r == ST_SLEEP, boot_r};
				ADDR_CONTROL:     pslverr_nxt = 1'b0;
				default:          pslverr_nxt = 1'b1;
			endcase
		end
		// Writes land at the completing edge, while pready is high
		if (psel && penable && pready_r && pwrite && paddr == ADDR_TIMING_WORD) begin
			word_nxt    = pwdata[15:0];
			restart_nxt = 1'b1;
		end
		if (psel && penable && pready_r && pwrite && paddr == ADDR_CONTROL && pwdata[0]) begin
			boot_nxt = 1'b1;
		end
	end

	// Detector duty gate
	always_comb begin
		duty_cnt_nxt = duty_cnt_r + 16'h1;
		det_on_nxt   = det_on_r;
		if (duty_f == 2'h0) begin
			det_on_nxt   = 1'b1;
			duty_cnt_nxt = 16'h0;
		end else if (det_on_r && duty_cnt_r >= 16'(ON_CYC - 1)) begin
			det_on_nxt   = 1'b0;
			duty_cnt_nxt = 16'h0;
		end else if (!det_on_r && duty_cnt_r >= off_cycles(duty_f) - 16'h1) begin
			det_on_nxt   = 1'b1;
			duty_cnt_nxt = 16'h0;
		end
	end

	// Fade timer and power state
	always_comb begin
		fade_cnt_nxt = fade_cnt_r;
		state_nxt    = state_r;
		case (state_r)
			ST_ACTIVE: begin
				if (cmd_s) begin
					fade_cnt_nxt = 24'h0;
				end else if (!busy_s && det_on_r) begin
					if (field_s) begin
						fade_cnt_nxt = 24'h0;
					end else if (fade_cnt_r >= fade_cycles(fade_f) - 24'h1) begin
						state_nxt    = ST_SLEEP;
						fade_cnt_nxt = 24'h0;
					end else begin
						fade_cnt_nxt = fade_cnt_r + 24'h1;
					end
				end else if (!busy_s && fade_cnt_r != 24'h0) begin // Off: only a missed field
					if (fade_cnt_r >= fade_cycles(fade_f) - 24'h1) begin
						state_nxt    = ST_SLEEP;
						fade_cnt_nxt = 24'h0;
					end else begin
						fade_cnt_nxt = fade_cnt_r + 24'h1;
					end
				end
				if (init_done) begin
					state_nxt = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (det_on_r && field_s) begin
					state_nxt = ST_ACTIVE;
				end
			end
			default: state_nxt = ST_ACTIVE;
		endcase
	end

	// Free 10 ms tick; timers start between ticks
	always_comb begin
		tick_nxt     = 1'b0;
		tick_cnt_nxt = tick_cnt_r + 20'h1;
		if (tick_cnt_r == 20'(TICK_CYC - 1)) begin
			tick_cnt_nxt = 20'h0;
			tick_nxt     = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			word_r     <= RESET_TIMING_WORD;
			sens_r     <= RESET_SENS;
			prev_r     <= 3'h7;
			boot_r     <= 1'b0;
			duty_cnt_r <= 16'h0;
			det_on_r   <= 1'b1;
			fade_cnt_r <= 24'h0;
			state_r    <= ST_ACTIVE;
			tick_cnt_r <= 20'h0;
			tick_r     <= 1'b0;
			restart_r  <= 1'b0;
			prdata_r   <= 32'h0;
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
		end else begin
			word_r     <= word_nxt;
			sens_r     <= sens_nxt;
			prev_r     <= prev_nxt;
			boot_r     <= boot_nxt;
			duty_cnt_r <= duty_cnt_nxt;
			det_on_r   <= det_on_nxt;
			fade_cnt_r <= fade_cnt_nxt;
			state_r    <= state_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			tick_r     <= tick_nxt;
			restart_r  <= restart_nxt;
			prdata_r   <= prdata_nxt;
			pready_r   <= pready_nxt;
			pslverr_r  <= pslverr_nxt;
		end
	end

	// Initial detection timeout, 10 ms steps
	interval_timer u_init_timer (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.i_start   (restart_r),
		.i_tick    (tick_r),
		.i_count   ({17'h0, init_f}),
		.o_done    (init_done)
	);

	// Idle timeout, scaled by units
	interval_timer u_idle_timer (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.i_start   (restart_r),
		.i_tick    (tick_r),
		.i_count   (idle_count),
		.o_done    (idle_done)
	);

	// Output flops
	logic [3:0] sens_out_r;
	logic       sleep_r;
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			sens_out_r <= 4'h2;
			sleep_r    <= 1'b0;
		end else begin
			sens_out_r <= sens_dec;
			sleep_r    <= (state_nxt == ST_SLEEP);
		end
	end

	assign prdata            = prdata_r;
	assign pready            = pready_r;
	assign pslverr           = pslverr_r;
	assign o_detector_en     = det_on_r;
	assign o_sleep           = sleep_r;
	assign o_sensitivity_sel = sens_out_r;
	assign o_init_timeout    = init_done;
	assign o_idle_timeout    = idle_done;
endmodule

// ### test/batt_duty_monitor.sv
module batt_duty_monitor
	import batt_duty_pkg::*;
(
	input wire logic        i_clk_sys,
	input wire logic        i_srst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        i_field_detect,
	input wire logic        i_rf_cmd_busy,
	input wire logic        i_rf_cmd_rx,
	input wire logic        i_rf_energize,
	input wire logic        i_battery_ok,
	input wire logic        i_battery_assisted_mode,
	input wire logic        i_serial_boot_command,
	input wire logic        o_detector_en,
	input wire logic        o_sleep,
	input wire logic [3:0]  o_sensitivity_sel,
	input wire logic        o_idle_timeout
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int OFF [4] = '{0, DET_OFF0_NS / CLK_NS, DET_OFF1_NS / CLK_NS, DET_OFF2_NS / CLK_NS};
	localparam int FD [4]  = '{FADE0_NS / CLK_NS, FADE1_NS / CLK_NS, FADE2_NS / CLK_NS, FADE3_NS / CLK_NS};
	logic [15:0] word_r;
	logic [23:0] hi_r, lo_r, fade_r, rx_r;
	logic [4:0]  boot_r;
	logic [2:0]  ed_r;
	logic        wr, bt;
	// Completed writes and boot causes
	assign wr = psel & penable & pready & pwrite;
	assign bt = (i_serial_boot_command & !ed_r[0])
		| (i_rf_energize & !ed_r[1] & !i_battery_assisted_mode)
		| (i_battery_ok & !ed_r[2] & i_battery_assisted_mode)
		| (wr & (paddr == ADDR_CONTROL) & pwdata[0]);
	// Shadow word and phase counters
	always_ff @(posedge i_clk_sys) begin
		ed_r <= i_srst ? 3'h7 : {i_battery_ok, i_rf_energize, i_serial_boot_command};
		word_r <= i_srst ? RESET_TIMING_WORD : (wr && paddr == ADDR_TIMING_WORD) ? pwdata[15:0] : word_r;
		hi_r <= (o_detector_en && !wr) ? hi_r + 24'h1 : '0;
		lo_r <= o_detector_en ? '0 : lo_r + 24'h1;
		fade_r <= (i_field_detect || i_rf_cmd_busy) ? '0 : fade_r + 24'h1;
		rx_r <= i_rf_cmd_rx ? '0 : rx_r + 24'h1;
		boot_r <= (i_srst || (boot_r == 5'h1f && !bt)) ? 5'h1f : bt ? '0 : boot_r + 5'h1;
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	AST_DET_HI: assert property (o_detector_en && word_r[15:14] != 0 |-> hi_r < DET_ON_NS / CLK_NS)
		else $error("detector on phase too long");
	AST_DET_LO: assert property (!o_detector_en |-> lo_r < OFF[word_r[15:14]])
		else $error("detector off phase too long");
	AST_FADE: assert property ($rose(o_sleep) |-> fade_r + 2 >= FD[word_r[13:12]])
		else $error("sleep before fade time");
	AST_CMD: assert property ($rose(o_sleep) |-> rx_r + 2 >= FD[word_r[13:12]])
		else $error("sleep too soon after command");
	AST_ONEHOT: assert property ($onehot(o_sensitivity_sel))
		else $error("sensitivity select not one-hot");
	AST_SENS_HOLD: assert property (o_sensitivity_sel != $past(o_sensitivity_sel) |-> boot_r < 16)
		else $error("sensitivity changed without boot");
	AST_SENS_BOOT: assert property (boot_r == 12 |-> o_sensitivity_sel == 4'h1 << word_r[1:0])
		else $error("sensitivity not latched at boot");
	AST_IDLE_ZERO: assert property (word_r[5:2] == 0 |-> !$rose(o_idle_timeout))
		else $error("idle timeout with zero value");
	cover property ($rose(o_sleep));
	cover property ($fell(o_detector_en));
	cover property (boot_r == 12);
endmodule

// ### test/rf_reader_model.sv
module rf_reader_model (
	input  wire logic        i_clk_sys,
	input  wire logic        i_field_on,
	input  wire logic        i_cmd_go,
	input  wire logic [15:0] i_len,
	output logic             o_field,
	output logic             o_busy,
	output logic             o_rx
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	// Carrier level and command progress
	assign o_field = i_field_on;
	assign o_busy = n > 1;
	assign o_rx = n == 1;
	// A command keeps the tag busy, then ends with a receive strobe
	always @(posedge i_clk_sys) begin
		n <= i_cmd_go ? int'(i_len) : (n > 0) ? n - 1 : 0;
	end
endmodule

// ### test/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import batt_duty_pkg::*;
	logic        i_clk_sys = 0, i_srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic        field_on = 1, cmd_go = 0, i_battery_ok = 0, i_serial_boot_command = 0;
	logic        i_battery_assisted_mode = 0, pready, pslverr, er, i_rf_energize;
	logic        i_field_detect, i_rf_cmd_busy, i_rf_cmd_rx, o_detector_en, o_sleep;
	logic        o_init_timeout, o_idle_timeout;
	logic [3:0]  o_sensitivity_sel;
	logic [7:0]  paddr = '0;
	logic [15:0] cmd_len = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	int          num_errors = 0, check_count = 0;
	int          offc [4] = '{0, DET_OFF0_NS / CLK_NS, DET_OFF1_NS / CLK_NS, DET_OFF2_NS / CLK_NS};
	always #5 i_clk_sys = ~i_clk_sys;
	assign i_rf_energize = i_field_detect;
	battery_duty_cycle_control u_battery_duty_cycle_control (.*);
	rf_reader_model u_rf_reader_model (.i_clk_sys(i_clk_sys), .i_field_on(field_on),
		.i_cmd_go(cmd_go), .i_len(cmd_len), .o_field(i_field_detect),
		.o_busy(i_rf_cmd_busy), .o_rx(i_rf_cmd_rx));
	// One bus transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge i_clk_sys);
		penable <= 1;
		do @(posedge i_clk_sys); while (pready !== 1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic check_range(input string s, input int lo, input int hi, input int g);
		check_count++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("BAD %s exp %0d..%0d got %0d", s, lo, hi, g);
		end
	endtask
	// Cycles until detector (sel 1) or sleep (sel 0) reaches v
	task automatic until_level(input int sel, input logic v, output int k);
		k = 0;
		while ((sel ? o_detector_en : o_sleep) !== v && k < 50000) begin
			@(posedge i_clk_sys);
			k++;
		end
	endtask
	task automatic t_regs;
		apb(0, ADDR_TIMING_WORD, '0);
		check("word reset", {16'h0, RESET_TIMING_WORD}, rd);
		apb(0, 8'h10, '0);
		check("unmapped error", 1, er);
		check("sens reset", 4'h2, o_sensitivity_sel);
	endtask
	task automatic t_sens;
		for (int k = 0; k < 4; k++) begin
			apb(1, ADDR_TIMING_WORD, {16'hffff, 14'h0, k[1:0]});
			apb(0, ADDR_TIMING_WORD, '0);
			check("word readback", k, rd);
			check("sens held", k ? 4'h1 << (k - 1) : 4'h2, o_sensitivity_sel);
			case (k)
				0: i_serial_boot_command <= 1;
				1: field_on <= 0;
				2: i_battery_assisted_mode <= 1;
				default: apb(1, ADDR_CONTROL, 1);
			endcase
			repeat (5) @(posedge i_clk_sys);
			{i_serial_boot_command, field_on} <= 2'b01;
			i_battery_ok <= i_battery_assisted_mode;
			repeat (16) @(posedge i_clk_sys);
			check("sens after boot", 4'h1 << k, o_sensitivity_sel);
			apb(0, ADDR_LIVE_WORD, '0);
			check("live sens", k, rd);
		end
	endtask
	task automatic t_fade;
		int k;
		field_on <= 0;
		repeat (1000) @(posedge i_clk_sys);
		{cmd_go, cmd_len} <= {1'b1, 16'd3000};
		@(posedge i_clk_sys);
		cmd_go <= 0;
		@(posedge i_clk_sys iff i_rf_cmd_rx);
		check("awake during command", 0, o_sleep);
		until_level(0, 1, k);
		check_range("fade to sleep", FADE0_NS / CLK_NS - 1, FADE0_NS / CLK_NS + 6, k);
		field_on <= 1;
		repeat (20) @(posedge i_clk_sys);
		check("wake on field", 0, o_sleep);
	endtask
	task automatic t_duty;
		int k;
		for (int d = 1; d < 4; d++) begin
			apb(1, ADDR_TIMING_WORD, {16'h0, d[1:0], 14'h013f});
			until_level(1, 0, k);
			until_level(1, 1, k);
			check_range("detector off", offc[d] - 1, offc[d] + 1, k);
		end
		until_level(1, 0, k);
		check_range("detector on", DET_ON_NS / CLK_NS - 1, DET_ON_NS / CLK_NS + 1, k);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge i_clk_sys);
		i_srst <= 0;
		t_regs;
		t_sens;
		t_fade;
		t_duty;
		check("init timeout off", 0, o_init_timeout);
		check("idle timeout off", 0, o_idle_timeout);
		test_done;
	end
	// Watchdog
	initial begin
		repeat (98000) @(posedge i_clk_sys);
		num_errors++;
		test_done;
	end
endmodule
bind battery_duty_cycle_control batt_duty_monitor u_batt_duty_monitor (.*);
